// File: rtl/overtemp_fault_response.sv
// Overtemperature supervision, status reporting and restart_wait_period restart control.
`timescale 1ns/1ps
`include "overtemp_defines.svh"

// Contract
// - Fault sets summary and fault bits, alerts host.
// - Action 00b keeps running, only reports.
// - Action 01b runs for delay, then shuts down.
// - Action 10b shuts down at once, then retries.
// - Action 11b holds off until below warning.
// - Retry zero latches off after shutdown.
// - Retry 1-6: restart_wait_period wait, limited attempts, latch.
// - Attempts while still hot are counted silently.
// - Retry seven retries forever until off/success.
// - Delay zero: 10 ms, restart_wait_period equals rise time.
// - Delay 1-7: 1-7 ms, restart_wait_period 2-4 rise times.
// - Unsupported write flags invalid data, alerts host.
// - Fault releases below warning limit, allowing restart.
// - Warning above fault limit: fixed 20 C hysteresis.
// - Clear faults in hold mode may keep faulted.
// - Reaching warning sets summary and warning bits.
// - Warning word: exponent resets zero, mantissa restored.
// - Restore rounds warning to whole degree, 0-160 or 255.
// - Warning limit 255 C disables warning detection.
// - Response byte at 50h, byte access, live.
// - Warning limit word at 51h, linear degrees.
// - Fault when temperature exceeds fault limit.
module overtemp_fault_response #(
   parameter int CYCLES_PER_MS = `OT_MS_NS / `OT_CLK_NS,
   parameter int RISE_W        = 24
) (
   input  wire logic                    clock,
   input  wire logic                    reset_n,
   input  wire logic                    link_clock,
   input  wire logic                    link_cmd_strobe,
   input  wire logic                    link_cmd_write,
   input  wire logic [7:0]              link_cmd_code,
   input  wire logic [15:0]             link_cmd_wdata,
   output logic                         link_cmd_busy,
   output logic                         link_rsp_done,
   output logic [15:0]                  link_rsp_rdata,
   input  wire logic signed [15:0]      temp_reading_deg,
   input  wire logic signed [15:0]      fault_limit_deg,
   input  wire logic [RISE_W-1:0]       output_rise_time,
   input  wire logic                    enable_cmd,
   input  wire logic                    clear_faults,
   input  wire logic                    nvm_restore,
   input  wire logic [7:0]              nvm_response,
   input  wire logic [15:0]             nvm_warn_word,
   output logic                         power_enable,
   output overtemp_pkg::status_t        status,
   output logic                         alert_n
);

   // Linear word to whole degrees, rounded to nearest and saturated.
   function automatic logic signed [15:0] lin_to_deg(input logic [15:0] w);
      logic signed [4:0]  e;
      logic signed [31:0] m;
      logic [4:0]         n;
      e = w[`OT_EXP_HI:`OT_EXP_LO];
      m = {{21{w[`OT_MAN_HI]}}, w[`OT_MAN_HI:`OT_MAN_LO]};
      n = 5'(-e);
      if (e >= 5'sh00) begin
         m = m <<< e;
      end else begin
         m = (m + (32'sh00000001 <<< (n - 5'h01))) >>> n;
      end
      if (m > 32'sh00007FFF) begin
         lin_to_deg = 16'sh7FFF;
      end else if (m < -32'sh00008000) begin
         lin_to_deg = -16'sh7FFF - 16'sh0001;
      end else begin
         lin_to_deg = m[15:0];
      end
   endfunction : lin_to_deg

   function automatic logic warn_supported(input logic signed [15:0] d);
      warn_supported = (d >= `OT_WARN_MIN_DEG && d <= `OT_WARN_MAX_DEG)
                       || d == `OT_DISABLE_DEG;
   endfunction : warn_supported

   // Restart_wait_period multiple: 0 -> 1, 1..3 -> 2, 4..6 -> 3, 7 -> 4 rise times.
   function automatic logic [31:0] restart_wait_period_cycles(input logic [2:0] dly,
                                                 input logic [RISE_W-1:0] r);
      logic [2:0] mult;
      mult = (dly == 3'h0) ? 3'h1 : 3'(3'h2 + (dly - 3'h1) / 3'h3);
      restart_wait_period_cycles = 32'(r) * 32'(mult);
   endfunction : restart_wait_period_cycles

   // ---------------- Link domain ----------------
   overtemp_pkg::link_req_t req_ff;
   logic                    req_tgl_ff;
   logic                    ack_s1_ff, ack_s2_ff, ack_s3_ff;
   logic                    busy_ff, done_ff;
   logic [15:0]             rsp_rdata_ff;
   logic                    ack_tgl_ff;
   logic [15:0]             rdata_ff;

   // The whole request is latched and only its toggle crosses to the core;
   // busy refuses a second request until the answer has come back.
   wire req_take = link_cmd_strobe & ~busy_ff;
   wire ack_seen = ack_s2_ff ^ ack_s3_ff;

   always_ff @(posedge link_clock or negedge reset_n) begin
      if (!reset_n) begin
         req_ff     <= '0;
         req_tgl_ff <= 1'b0;
         busy_ff    <= 1'b0;
      end else if (req_take) begin
         req_ff     <= '{link_cmd_write, link_cmd_code, link_cmd_wdata};
         req_tgl_ff <= ~req_tgl_ff;
         busy_ff    <= 1'b1;
      end else if (ack_seen) begin
         busy_ff    <= 1'b0;
      end
   end

   // Read data is held by the core from the ack toggle on, so it is stable.
   always_ff @(posedge link_clock or negedge reset_n) begin
      if (!reset_n) begin
         ack_s1_ff    <= 1'b0;
         ack_s2_ff    <= 1'b0;
         ack_s3_ff    <= 1'b0;
         done_ff      <= 1'b0;
         rsp_rdata_ff <= 16'h0000;
      end else begin
         ack_s1_ff <= ack_tgl_ff;
         ack_s2_ff <= ack_s1_ff;
         ack_s3_ff <= ack_s2_ff;
         done_ff   <= ack_seen;
         if (ack_seen) begin
            rsp_rdata_ff <= rdata_ff;
         end
      end
   end

   assign link_cmd_busy  = busy_ff;
   assign link_rsp_done  = done_ff;
   assign link_rsp_rdata = rsp_rdata_ff;

   // ---------------- Core domain ----------------
   logic                  req_s1_ff, req_s2_ff, req_s3_ff;
   logic [7:0]            response_ff;
   logic [15:0]           warn_word_ff;
   logic                  fault_cond_ff;
   overtemp_pkg::status_t status_ff, nxt_status;
   overtemp_pkg::state_t  state_ff, nxt_state;
   logic [31:0]           timer_ff, nxt_timer;
   logic [2:0]            tries_ff, nxt_tries;
   logic                  alert_n_ff;

   // The request word is read straight from the link side: it cannot
   // change while busy is up, so only the toggle needs synchronising.
   wire req_seen = req_s2_ff ^ req_s3_ff;
   wire wr_req   = req_seen & req_ff.write;
   wire hit_resp = req_ff.code == `OT_CMD_RESPONSE;
   wire hit_warn = req_ff.code == `OT_CMD_WARN_LIMIT;
   wire signed [15:0] wr_deg   = lin_to_deg(req_ff.wdata);
   wire               wr_ok    = warn_supported(wr_deg);
   // Every response byte is a defined setting; only the limit can be bad.
   wire wr_resp  = wr_req & hit_resp;
   wire wr_warn  = wr_req & hit_warn & wr_ok;
   wire wr_bad   = wr_req & hit_warn & ~wr_ok;

   // Unknown codes read as zero; writes to them are dropped.
   wire [15:0] rd_value = hit_resp ? {8'h00, response_ff} :
                          hit_warn ? warn_word_ff : 16'h0000;

   wire signed [15:0] nvm_deg = lin_to_deg(nvm_warn_word);
   wire signed [15:0] nvm_clamped =
      (nvm_deg == `OT_DISABLE_DEG) ? nvm_deg :
      (nvm_deg < `OT_WARN_MIN_DEG) ? `OT_WARN_MIN_DEG :
      (nvm_deg > `OT_WARN_MAX_DEG) ? `OT_WARN_MAX_DEG : nvm_deg;
   wire [15:0] nvm_word = {`OT_WARN_EXP_RESET, nvm_clamped[10:0]};

   wire overtemp_pkg::action_t action =
      overtemp_pkg::action_t'(response_ff[`OT_ACT_HI:`OT_ACT_LO]);
   wire [2:0] retry = response_ff[`RESTART_COUNT_FIELD_HI:`RESTART_COUNT_FIELD_LO];
   wire [2:0] dly   = response_ff[`SHUTDOWN_DELAY_FIELD_HI:`SHUTDOWN_DELAY_FIELD_LO];

   // Limits compare in whole degrees; a limit of 255 switches it off.
   wire signed [15:0] warn_deg = lin_to_deg(warn_word_ff);
   wire warn_on   = warn_deg != `OT_DISABLE_DEG;
   wire fault_on  = fault_limit_deg != `OT_DISABLE_DEG;
   wire use_warn  = warn_on && warn_deg <= fault_limit_deg;
   wire signed [15:0] release_deg =
      use_warn ? warn_deg : fault_limit_deg - `OT_HYST_DEG;
   wire over_fault = fault_on && temp_reading_deg > fault_limit_deg;
   wire below_rel  = temp_reading_deg < release_deg;
   wire warn_hit   = warn_on && temp_reading_deg >= warn_deg;
   wire fault_new  = over_fault & ~fault_cond_ff;
   wire release_ev = fault_cond_ff & below_rel & ~over_fault;
   // Clear faults drops the condition without a release event, so a
   // held-off converter waits for a new fault and release, or off/on.
   // A fault that outlasts the clear is detected afresh one edge later.
   wire nxt_fault_cond = ~clear_faults &
      (over_fault | (fault_cond_ff & ~below_rel));

   // One down-counter times the shutdown delay, restart wait and start.
   wire [31:0] delay_ms = (dly == 3'h0) ? `OT_DELAY0_MS : 32'(dly);
   wire [31:0] delay_cyc = delay_ms * 32'(CYCLES_PER_MS);
   wire [31:0] restart_wait_period_cyc = restart_wait_period_cycles(dly, output_rise_time);
   wire [2:0]  tries_inc  = tries_ff + 3'h1;
   wire        limited    = retry != `RESTART_COUNT_FIELD_FOREVER;
   wire        timer_done = timer_ff == 32'h00000000;

   // Where a shutdown leads: latched off, or into the restart wait.
   wire overtemp_pkg::state_t shut_state = (retry == `RESTART_COUNT_FIELD_NONE) ?
      overtemp_pkg::ST_LATCH : overtemp_pkg::ST_RESTART_WAIT_PERIOD;

   // Status bits stay set until a clear; the alert follows them.
   always_comb begin
      nxt_status = status_ff;
      if (clear_faults) begin
         nxt_status = '0;
      end
      // Hardware set wins over a clear in the same cycle.
      if (fault_new) begin
         nxt_status.temp_summary          = 1'b1;
         nxt_status.temp_fault_status_bit = 1'b1;
      end
      if (warn_hit) begin
         nxt_status.temp_summary            = 1'b1;
         nxt_status.temp_warning_status_bit = 1'b1;
      end
      if (wr_bad) begin
         nxt_status.cml_invalid_data = 1'b1;
      end
   end

   // Dropping the enable command returns to run and forgets spent retries;
   // that is the only way out of the latched-off state.
   always_comb begin
      nxt_state = state_ff;
      nxt_timer = timer_done ? timer_ff : timer_ff - 32'h00000001;
      nxt_tries = tries_ff;
      case (state_ff)
         overtemp_pkg::ST_RUN: begin
            if (fault_cond_ff) begin
               case (action)
                  overtemp_pkg::ACT_IGNORE: nxt_state = state_ff;
                  overtemp_pkg::ACT_DELAYED: begin
                     nxt_state = overtemp_pkg::ST_DELAY;
                     nxt_timer = delay_cyc;
                  end
                  overtemp_pkg::ACT_IMMEDIATE: begin
                     nxt_state = shut_state;
                     nxt_timer = restart_wait_period_cyc;
                  end
                  default: nxt_state = overtemp_pkg::ST_HOLD;
               endcase
            end
         end
         overtemp_pkg::ST_DELAY: begin
            if (!fault_cond_ff || action == overtemp_pkg::ACT_IGNORE) begin
               nxt_state = overtemp_pkg::ST_RUN;
            end else if (timer_done) begin
               nxt_state = shut_state;
               nxt_timer = restart_wait_period_cyc;
            end
         end
         overtemp_pkg::ST_HOLD: begin
            if (release_ev) begin
               nxt_state = shut_state;
               nxt_timer = restart_wait_period_cyc;
            end
         end
         overtemp_pkg::ST_RESTART_WAIT_PERIOD: begin
            if (timer_done) begin
               nxt_tries = tries_inc;
               if (fault_cond_ff) begin
                  // Still hot: the attempt is spent without switching.
                  if (limited && tries_inc >= retry) begin
                     nxt_state = overtemp_pkg::ST_LATCH;
                  end else begin
                     nxt_timer = restart_wait_period_cyc;
                  end
               end else begin
                  nxt_state = overtemp_pkg::ST_START;
                  nxt_timer = 32'(output_rise_time);
               end
            end
         end
         overtemp_pkg::ST_START: begin
            // A fault while starting spends the attempt just made.
            if (fault_cond_ff) begin
               if (limited && tries_ff >= retry) begin
                  nxt_state = overtemp_pkg::ST_LATCH;
               end else begin
                  nxt_state = overtemp_pkg::ST_RESTART_WAIT_PERIOD;
                  nxt_timer = restart_wait_period_cyc;
               end
            end else if (timer_done) begin
               nxt_state = overtemp_pkg::ST_RUN;
               nxt_tries = 3'h0;
            end
         end
         overtemp_pkg::ST_LATCH: nxt_state = state_ff;
         default: nxt_state = overtemp_pkg::ST_RUN;
      endcase
      if (!enable_cmd) begin
         nxt_state = overtemp_pkg::ST_RUN;
         nxt_timer = 32'h00000000;
         nxt_tries = 3'h0;
      end
   end

   // Switching is allowed while running, in the delay, and while starting.
   wire run_on = state_ff == overtemp_pkg::ST_RUN ||
                 state_ff == overtemp_pkg::ST_DELAY ||
                 state_ff == overtemp_pkg::ST_START;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         req_s1_ff <= 1'b0;
         req_s2_ff <= 1'b0;
         req_s3_ff <= 1'b0;
         ack_tgl_ff <= 1'b0;
         rdata_ff  <= 16'h0000;
      end else begin
         req_s1_ff <= req_tgl_ff;
         req_s2_ff <= req_s1_ff;
         req_s3_ff <= req_s2_ff;
         if (req_seen) begin
            ack_tgl_ff <= ~ack_tgl_ff;
            rdata_ff   <= rd_value;
         end
      end
   end

   // A restore takes priority over a bus write landing in the same cycle.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         response_ff  <= `OT_RESPONSE_RESET;
         warn_word_ff <= `OT_WARN_WORD_RESET;
      end else if (nvm_restore) begin
         response_ff  <= nvm_response;
         warn_word_ff <= nvm_word;
      end else begin
         if (wr_resp) begin
            response_ff <= req_ff.wdata[7:0];
         end
         if (wr_warn) begin
            warn_word_ff <= req_ff.wdata;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fault_cond_ff <= 1'b0;
         status_ff     <= '0;
         alert_n_ff    <= 1'b1;
         state_ff      <= overtemp_pkg::ST_RUN;
         timer_ff      <= 32'h00000000;
         tries_ff      <= 3'h0;
         power_enable  <= 1'b0;
      end else begin
         fault_cond_ff <= nxt_fault_cond;
         status_ff     <= nxt_status;
         alert_n_ff    <= ~(|nxt_status);
         state_ff      <= nxt_state;
         timer_ff      <= nxt_timer;
         tries_ff      <= nxt_tries;
         power_enable  <= enable_cmd & run_on;
      end
   end

   assign status  = status_ff;
   assign alert_n = alert_n_ff;

endmodule : overtemp_fault_response

// File: pkg/overtemp_defines.svh
// Command codes, field positions, reset values and timing counts.
`ifndef OVERTEMP_DEFINES_SVH
`define OVERTEMP_DEFINES_SVH

`define OT_CMD_RESPONSE      8'h50
`define OT_CMD_WARN_LIMIT    8'h51

`define OT_ACT_HI            7
`define OT_ACT_LO            6
`define RESTART_COUNT_FIELD_HI          5
`define RESTART_COUNT_FIELD_LO          3
`define SHUTDOWN_DELAY_FIELD_HI          2
`define SHUTDOWN_DELAY_FIELD_LO          0
`define OT_EXP_HI            15
`define OT_EXP_LO            11
`define OT_MAN_HI            10
`define OT_MAN_LO            0

`define OT_RESPONSE_RESET    8'h00
`define OT_WARN_EXP_RESET    5'h00
`define OT_WARN_WORD_RESET   16'h00A0

`define RESTART_COUNT_FIELD_NONE        3'h0
`define RESTART_COUNT_FIELD_FOREVER     3'h7
`define OT_WARN_MIN_DEG      16'sh0000
`define OT_WARN_MAX_DEG      16'sh00A0
`define OT_DISABLE_DEG       16'sh00FF
`define OT_HYST_DEG          16'sh0014

`define OT_MS_NS             32'h000F4240
`define OT_CLK_NS            32'h00000005
`define OT_DELAY0_MS         32'h0000000A

`endif

// File: pkg/overtemp_pkg.sv
// Types shared by the overtemperature fault response block.
package overtemp_pkg;

   typedef enum logic [5:0] {
      ST_RUN    = 6'h01,
      ST_DELAY  = 6'h02,
      ST_HOLD   = 6'h04,
      ST_RESTART_WAIT_PERIOD = 6'h08,
      ST_START  = 6'h10,
      ST_LATCH  = 6'h20
   } state_t;

   typedef enum logic [1:0] {
      ACT_IGNORE    = 2'h0,
      ACT_DELAYED   = 2'h1,
      ACT_IMMEDIATE = 2'h2,
      ACT_HOLD      = 2'h3
   } action_t;

   typedef struct packed {
      logic        write;
      logic [7:0]  code;
      logic [15:0] wdata;
   } link_req_t;

   typedef struct packed {
      logic temp_summary;
      logic temp_fault_status_bit;
      logic temp_warning_status_bit;
      logic cml_invalid_data;
   } status_t;

endpackage : overtemp_pkg

// File: tb/overtemp_monitor.sv
// Checker of the overtemperature block ports, bound to its top module.
`timescale 1ns/1ps
module overtemp_monitor #(
   parameter int CYCLES_PER_MS = 10,
   parameter int RISE_W        = 24
) (
   input wire logic                  clock,
   input wire logic                  reset_n,
   input wire logic                  link_clock,
   input wire logic                  link_cmd_strobe,
   input wire logic                  link_cmd_busy,
   input wire logic                  link_rsp_done,
   input wire logic signed [15:0]    temp_reading_deg,
   input wire logic signed [15:0]    fault_limit_deg,
   input wire logic                  enable_cmd,
   input wire logic                  clear_faults,
   input wire logic                  power_enable,
   input wire overtemp_pkg::status_t status,
   input wire logic                  alert_n
);
   chk_alert_on_status:
      assert property (@(posedge clock) disable iff (!reset_n)
         $rose(|status) |-> ##[0:1] !alert_n) else $error("alert missing");
   chk_summary_tied:
      assert property (@(posedge clock) disable iff (!reset_n)
         (status.temp_fault_status_bit || status.temp_warning_status_bit)
         |-> status.temp_summary) else $error("summary bit missing");
   // A clear drops the held condition, so detection resumes one edge on.
   chk_fault_detect:
      assert property (@(posedge clock) disable iff (!reset_n)
         (temp_reading_deg > fault_limit_deg && !clear_faults &&
          fault_limit_deg != 16'sh00FF) |=> status.temp_fault_status_bit)
         else $error("fault not flagged");
   chk_fault_sticky:
      assert property (@(posedge clock) disable iff (!reset_n)
         (status.temp_fault_status_bit && !clear_faults)
         |=> status.temp_fault_status_bit) else $error("fault bit lost");
   chk_power_off:
      assert property (@(posedge clock) disable iff (!reset_n)
         !enable_cmd |=> !power_enable) else $error("power while off");
   chk_done_pulse:
      assert property (@(posedge link_clock) disable iff (!reset_n)
         link_rsp_done |=> !link_rsp_done) else $error("done too long");
   chk_take_answer:
      assert property (@(posedge link_clock) disable iff (!reset_n)
         (link_cmd_strobe && !link_cmd_busy)
         |=> link_cmd_busy ##[1:8] link_rsp_done) else $error("no answer");
   chk_busy_drop:
      assert property (@(posedge link_clock) disable iff (!reset_n)
         link_rsp_done |-> !link_cmd_busy) else $error("busy with done");
   cov_fault: cover property (@(posedge clock) disable iff (!reset_n)
      $rose(status.temp_fault_status_bit));
   cov_shutdown: cover property (@(posedge clock) disable iff (!reset_n)
      $fell(power_enable) && enable_cmd);
   cov_done: cover property (@(posedge link_clock) disable iff (!reset_n)
      link_rsp_done);
endmodule : overtemp_monitor

bind overtemp_fault_response overtemp_monitor #(
   .CYCLES_PER_MS(CYCLES_PER_MS), .RISE_W(RISE_W)) i_overtemp_monitor (
   .clock(clock), .reset_n(reset_n), .link_clock(link_clock),
   .link_cmd_strobe(link_cmd_strobe), .link_cmd_busy(link_cmd_busy),
   .link_rsp_done(link_rsp_done), .temp_reading_deg(temp_reading_deg),
   .fault_limit_deg(fault_limit_deg), .enable_cmd(enable_cmd),
   .clear_faults(clear_faults), .power_enable(power_enable),
   .status(status), .alert_n(alert_n));

// File: tb/overtemp_host_model.sv
// Host side model that issues byte and word commands on the link.
`timescale 1ns/1ps
module overtemp_host_model (
   input  wire logic        link_clock,
   input  wire logic        link_cmd_busy,
   input  wire logic        link_rsp_done,
   input  wire logic [15:0] link_rsp_rdata,
   output logic             link_cmd_strobe,
   output logic             link_cmd_write,
   output logic [7:0]       link_cmd_code,
   output logic [15:0]      link_cmd_wdata
);
   initial begin
      link_cmd_strobe = 1'b0;
      link_cmd_write  = 1'b0;
      link_cmd_code   = 8'h00;
      link_cmd_wdata  = 16'hA5C3;
   end

   // Only one request is ever outstanding, so busy is low when we start.
   task automatic xfer(input logic wr, input logic [7:0] code,
                       input logic [15:0] data, output logic [15:0] rd,
                       output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      rd = 16'h0000;
      @(negedge link_clock);
      while (link_cmd_busy !== 1'b0 && n < 20) begin
         @(negedge link_clock);
         n++;
      end
      link_cmd_strobe = 1'b1;
      link_cmd_write  = wr;
      link_cmd_code   = code;
      // A byte command carries one byte, so the upper byte is junk.
      link_cmd_wdata  = (code == 8'h50) ?
                        {~data[7:0], data[7:0]} : data;
      @(negedge link_clock);
      link_cmd_strobe = 1'b0;
      link_cmd_code   = ~code;
      link_cmd_wdata  = ~link_cmd_wdata;
      n = 0;
      while (link_rsp_done !== 1'b1 && n < 20) begin
         @(negedge link_clock);
         n++;
      end
      ok = (link_rsp_done === 1'b1);
      rd = link_rsp_rdata;
   endtask : xfer
endmodule : overtemp_host_model

// File: tb/overtemp_fault_response_bench.sv
// Self-checking bench of the overtemperature fault response block.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
   fail_count++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
   end end
module overtemp_fault_response_bench;
   localparam int CPM = 10;
   logic clock, reset_n, link_clock, enable_cmd, clear_faults, nvm_restore;
   logic link_cmd_strobe, link_cmd_write, link_cmd_busy, link_rsp_done;
   logic [7:0]            link_cmd_code, nvm_response;
   logic [15:0]           link_cmd_wdata, link_rsp_rdata, nvm_warn_word;
   logic [15:0]           last_rd;
   logic signed [15:0]    temp, flim;
   logic [23:0]           rise;
   logic                  power_enable, alert_n;
   overtemp_pkg::status_t status;
   int                    fail_count, num_checks, cycles;
   logic [7:0]            dly_resp [3] = '{8'h41, 8'h40, 8'h47};
   int                    dly_cyc [3] = '{CPM, 10 * CPM, 7 * CPM};
   logic [7:0]            hic_resp [4] = '{8'hB8, 8'hBA, 8'hBD, 8'hBF};
   int                    hic_len [4] = '{8, 16, 24, 32};

   overtemp_fault_response #(.CYCLES_PER_MS(CPM), .RISE_W(24))
      i_overtemp_fault_response (
      .clock(clock), .reset_n(reset_n), .link_clock(link_clock),
      .link_cmd_strobe(link_cmd_strobe), .link_cmd_write(link_cmd_write),
      .link_cmd_code(link_cmd_code), .link_cmd_wdata(link_cmd_wdata),
      .link_cmd_busy(link_cmd_busy), .link_rsp_done(link_rsp_done),
      .link_rsp_rdata(link_rsp_rdata), .temp_reading_deg(temp),
      .fault_limit_deg(flim), .output_rise_time(rise),
      .enable_cmd(enable_cmd), .clear_faults(clear_faults),
      .nvm_restore(nvm_restore), .nvm_response(nvm_response),
      .nvm_warn_word(nvm_warn_word), .power_enable(power_enable),
      .status(status), .alert_n(alert_n));

   overtemp_host_model i_overtemp_host_model (
      .link_clock(link_clock), .link_cmd_busy(link_cmd_busy),
      .link_rsp_done(link_rsp_done), .link_rsp_rdata(link_rsp_rdata),
      .link_cmd_strobe(link_cmd_strobe), .link_cmd_write(link_cmd_write),
      .link_cmd_code(link_cmd_code), .link_cmd_wdata(link_cmd_wdata));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      link_clock = 1'b0;
      #7;
      forever #15 link_clock = ~link_clock;
   end

   task automatic tally_and_finish();
      if (fail_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc

   task automatic acc(input logic wr, input logic [7:0] code,
                      input logic [15:0] data);
      logic ok;
      i_overtemp_host_model.xfer(wr, code, data, last_rd, ok);
      @(negedge clock);
      `CHK("link answer", 1'b1, ok)
   endtask : acc

   // Cool first so that a clear never lands between the two limits.
   task automatic renew(input logic [7:0] resp);
      temp = 16'sh0019;
      enable_cmd = 1'b0;
      clear_faults = 1'b1;
      cyc(1);
      clear_faults = 1'b0;
      acc(1'b1, 8'h50, {8'h00, resp});
      enable_cmd = 1'b1;
      cyc(4);
   endtask : renew

   task automatic restore(input logic [15:0] word);
      nvm_warn_word = word;
      nvm_restore = 1'b1;
      cyc(1);
      nvm_restore = 1'b0;
      cyc(3);
   endtask : restore

   task automatic restart_wait_period(input logic [7:0] resp, input int h);
      int n;
      renew(resp);
      temp = 16'sh0065;
      n = 0;
      while (power_enable !== 1'b0 && n < 200) begin
         cyc(1);
         n++;
      end
      temp = 16'sh0019;
      n = 0;
      while (power_enable !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      `CHK("restart wait", 1'b1, n >= h - 3 && n <= h + 4)
   endtask : restart_wait_period

   initial begin
      {reset_n, enable_cmd, clear_faults, nvm_restore} = 4'h0;
      {nvm_response, nvm_warn_word} = 24'h000000;
      temp = 16'sh0019;
      flim = 16'sh0064;
      rise = 24'h000008;
      cyc(4);
      reset_n = 1'b1;
      cyc(3);
      acc(1'b0, 8'h50, 16'h0000);
      `CHK("response reset", 16'h0000, last_rd)
      acc(1'b0, 8'h51, 16'h0000);
      `CHK("warn reset", 16'h00A0, last_rd)
      acc(1'b0, 8'h33, 16'h0000);
      `CHK("unknown code", 16'h0000, last_rd)
      acc(1'b1, 8'h51, 16'h0050);
      acc(1'b1, 8'h51, 16'h00C8);
      cyc(4);
      `CHK("invalid data", 1'b1, status.cml_invalid_data)
      `CHK("alert", 1'b0, alert_n)
      acc(1'b0, 8'h51, 16'h0000);
      `CHK("warn word", 16'h0050, last_rd)
      renew(8'h00);
      temp = 16'sh0050;
      cyc(3);
      `CHK("warn status", 3'h5, status[3:1])
      renew(8'h00);
      temp = 16'sh0065;
      cyc(3);
      `CHK("fault status", 3'h7, status[3:1])
      `CHK("ignore runs", 1'b1, power_enable)
      clear_faults = 1'b1;
      cyc(1);
      clear_faults = 1'b0;
      cyc(2);
      `CHK("fault after clear", 1'b1, status.temp_fault_status_bit)
      renew(8'h80);
      temp = 16'sh0065;
      cyc(4);
      `CHK("immediate off", 1'b0, power_enable)
      temp = 16'sh0019;
      cyc(60);
      `CHK("latched off", 1'b0, power_enable)
      for (int i = 0; i < 3; i++) begin
         renew(dly_resp[i]);
         temp = 16'sh0065;
         cyc(dly_cyc[i] - 4);
         `CHK("delay runs", 1'b1, power_enable)
         cyc(8);
         `CHK("delay off", 1'b0, power_enable)
      end
      for (int i = 0; i < 4; i++) begin
         restart_wait_period(hic_resp[i], hic_len[i]);
      end
      renew(8'h90);
      temp = 16'sh0065;
      cyc(60);
      temp = 16'sh0019;
      cyc(40);
      `CHK("retries spent", 1'b0, power_enable)
      renew(8'hC8);
      temp = 16'sh0065;
      cyc(4);
      temp = 16'sh005A;
      cyc(40);
      `CHK("hold off", 1'b0, power_enable)
      temp = 16'sh0046;
      cyc(30);
      `CHK("hold restart", 1'b1, power_enable)
      acc(1'b1, 8'h51, 16'h00FF);
      renew(8'hB8);
      temp = 16'sh005A;
      cyc(3);
      `CHK("warn disabled", 1'b0, status.temp_warning_status_bit)
      temp = 16'sh0065;
      cyc(4);
      temp = 16'sh0055;
      cyc(60);
      `CHK("hysteresis hold", 1'b0, power_enable)
      temp = 16'sh004F;
      cyc(30);
      `CHK("hysteresis release", 1'b1, power_enable)
      nvm_response = 8'h80;
      restore(16'hF143);
      acc(1'b0, 8'h51, 16'h0000);
      `CHK("restored warn", 16'h0051, last_rd)
      acc(1'b0, 8'h50, 16'h0000);
      `CHK("restored response", 16'h0080, last_rd)
      restore(16'h00C8);
      acc(1'b0, 8'h51, 16'h0000);
      `CHK("clamped warn", 16'h00A0, last_rd)
      tally_and_finish();
   end
endmodule : overtemp_fault_response_bench
